/* File: inc/ssr_map.svh */
/*
 * register map, field positions, reset values and widths of the
 * synchronous serial slave receiver.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

`define SSR_ADDR_W 32
`define SSR_DATA_W 32
`define SSR_OFS_W 4
`define SSR_FRAME_W 8
`define SSR_CNT_W 4
`define SSR_PIN_IDLE 2'h3

// byte offsets
`define SSR_OFS_CTRL 4'h0
`define SSR_OFS_BUF 4'h4
`define SSR_OFS_STAT 4'h8
`define SSR_OFS_MASK 4'hc

// control register fields
`define SSR_CTRL_EN_BIT 7
`define SSR_CTRL_LEN_HI 2
`define SSR_CTRL_LEN_LO 0
`define SSR_CTRL_RST 8'h07
`define SSR_CTRL_WMASK 8'h87

// status / mask fields
`define SSR_ST_W 2
`define SSR_ST_DONE_BIT 0
`define SSR_ST_OVR_BIT 1
`define SSR_ST_BUSY_BIT 2
`define SSR_ST_RST 2'h0
`define SSR_MASK_RST 2'h0
`define SSR_BUF_RST 8'h00

// axi responses
`define SSR_RESP_OKAY 2'h0
`define SSR_RESP_SLVERR 2'h2

`endif

/* File: inc/ssr_pkg.sv */
/*
 * types of the synchronous serial slave receiver.
 * assumes ssr_map.svh is on the include path.
 */
`include "ssr_map.svh"

package ssr_pkg;
    typedef logic [`SSR_FRAME_W-1:0] ssr_frame_t;
    typedef logic [`SSR_CNT_W-1:0] ssr_cnt_t;
    typedef logic [`SSR_ST_W-1:0] ssr_flags_t;
    typedef enum logic {SSR_IDLE, SSR_RECV} ssr_state_t;
endpackage : ssr_pkg

/* File: rtl/ssr_sync.sv */
/*
 * two-flop synchroniser for the serial clock and data pins.
 * assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module ssr_sync (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);
    logic [1:0] stage1;
    logic [1:0] next_stage1;
    logic [1:0] next_pin_sync;

    always_comb begin
        next_stage1 = pin_in;
        next_pin_sync = stage1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stage1 <= `SSR_PIN_IDLE;
            pin_sync <= `SSR_PIN_IDLE;
        end else begin
            stage1 <= next_stage1;
            pin_sync <= next_pin_sync;
        end
    end
endmodule : ssr_sync

`default_nettype wire

/* File: rtl/ssr_axil.sv */
/*
 * axi4-lite slave front end: turns bus transfers into one-cycle
 * register write and read strobes.
 * assumes the register core answers rd_data/rd_err combinationally.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module ssr_axil (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`SSR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`SSR_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`SSR_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [`SSR_ADDR_W-1:0] wr_addr,
    output logic [`SSR_DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [`SSR_ADDR_W-1:0] rd_addr,
    input wire logic [`SSR_DATA_W-1:0] rd_data,
    input wire logic rd_err
);
    logic aw_hold, w_hold;
    logic next_aw_hold, next_w_hold;
    logic [`SSR_ADDR_W-1:0] next_wr_addr;
    logic [`SSR_DATA_W-1:0] next_wr_data;
    logic [3:0] next_wr_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [`SSR_DATA_W-1:0] next_rdata;

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_en = aw_hold && w_hold && !s_axi_bvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strb = wr_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_hold = 1'b1;
            next_wr_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_hold = 1'b1;
            next_wr_data = s_axi_wdata;
            next_wr_strb = s_axi_wstrb;
        end
        if (wr_en) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_err ? `SSR_RESP_SLVERR : `SSR_RESP_OKAY;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (rd_en) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data;
            next_rresp = rd_err ? `SSR_RESP_SLVERR : `SSR_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSR_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SSR_RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strb <= next_wr_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule : ssr_axil

`default_nettype wire

/* File: rtl/ssr_receiver.sv */
/*
 * synchronous serial receiver, slave operation: receive clock and data
 * come from an external transmitter, registers over axi4-lite.
 * assumes instruction_start_strobe is a one-cycle pulse on clk_sys and
 * the serial pins are asynchronous to clk_sys.
 */
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module ssr_receiver (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`SSR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`SSR_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [`SSR_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic receive_clock_pin,
    input wire logic receive_data_pin,
    input wire logic instruction_start_strobe,
    output logic receive_complete,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    // bus front end
    logic wr_en, wr_err, rd_en, rd_err;
    logic [`SSR_ADDR_W-1:0] wr_addr, rd_addr;
    logic [`SSR_DATA_W-1:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    ssr_axil u_axil (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [1:0] pins_sync;
    logic rxc_s, rxd_s;

    ssr_sync u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin_in({receive_clock_pin, receive_data_pin}),
        .pin_sync(pins_sync)
    );

    assign rxc_s = pins_sync[1];
    assign rxd_s = pins_sync[0];

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [`SSR_OFS_W-1:0] reg_ofs(input logic [`SSR_ADDR_W-1:0] a);
        reg_ofs = a[`SSR_OFS_W-1:0];
    endfunction : reg_ofs

    function automatic logic reg_mapped(input logic [`SSR_ADDR_W-1:0] a);
        reg_mapped = (a[`SSR_ADDR_W-1:`SSR_OFS_W] == '0) && (a[1:0] == 2'h0);
    endfunction : reg_mapped

    // right-justify a frame shifted in from the top
    function automatic ssr_pkg::ssr_frame_t frame_align(input ssr_pkg::ssr_frame_t sr,
                                                        input ssr_pkg::ssr_cnt_t len);
        frame_align = sr >> (`SSR_CNT_W'(`SSR_FRAME_W) - len);
    endfunction : frame_align

    ////////////////////////////////////////////////////////////////////
    // registers and receive engine state
    logic [`SSR_FRAME_W-1:0] ctrl, next_ctrl;
    ssr_pkg::ssr_frame_t rx_buf, next_rx_buf;
    ssr_pkg::ssr_frame_t shift_reg, next_shift_reg;
    ssr_pkg::ssr_cnt_t bit_cnt, next_bit_cnt;
    ssr_pkg::ssr_flags_t status, next_status;
    ssr_pkg::ssr_flags_t mask, next_mask;
    ssr_pkg::ssr_state_t state, next_state;
    logic rxc_prev, next_rxc_prev;
    logic sample, next_sample;
    logic unread, next_unread;
    logic pend_done, next_pend_done;
    logic pend_ovr, next_pend_ovr;
    logic next_receive_complete;

    logic rx_en;
    logic shift_clk;
    logic frame_done;
    logic buf_read;
    ssr_pkg::ssr_cnt_t frame_len;
    ssr_pkg::ssr_cnt_t cnt_inc;
    ssr_pkg::ssr_frame_t shifted;
    ssr_pkg::ssr_flags_t stat_set;
    ssr_pkg::ssr_flags_t stat_clr;

    assign rx_en = ctrl[`SSR_CTRL_EN_BIT];
    assign frame_len = `SSR_CNT_W'(ctrl[`SSR_CTRL_LEN_HI:`SSR_CTRL_LEN_LO]) + `SSR_CNT_W'(1);
    assign shift_clk = rxc_s && !rxc_prev && rx_en;
    assign shifted = {sample, shift_reg[`SSR_FRAME_W-1:1]};
    assign cnt_inc = bit_cnt + `SSR_CNT_W'(1);
    assign frame_done = shift_clk && (cnt_inc == frame_len);
    assign buf_read = rd_en && reg_mapped(rd_addr) && (reg_ofs(rd_addr) == `SSR_OFS_BUF);
    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////
    // register read mux
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        if (!reg_mapped(rd_addr)) begin
            rd_err = 1'b1;
        end else if (reg_ofs(rd_addr) == `SSR_OFS_CTRL) begin
            rd_data[`SSR_FRAME_W-1:0] = ctrl;
        end else if (reg_ofs(rd_addr) == `SSR_OFS_BUF) begin
            rd_data[`SSR_FRAME_W-1:0] = rx_buf;
        end else if (reg_ofs(rd_addr) == `SSR_OFS_STAT) begin
            rd_data[`SSR_ST_W-1:0] = status;
            rd_data[`SSR_ST_BUSY_BIT] = (state == ssr_pkg::SSR_RECV);
        end else if (reg_ofs(rd_addr) == `SSR_OFS_MASK) begin
            rd_data[`SSR_ST_W-1:0] = mask;
        end else begin
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_comb begin
        next_ctrl = ctrl;
        next_mask = mask;
        stat_clr = '0;
        wr_err = 1'b0;
        if (wr_en) begin
            if (!reg_mapped(wr_addr)) begin
                wr_err = 1'b1;
            end else if (reg_ofs(wr_addr) == `SSR_OFS_CTRL) begin
                if (wr_strb[0]) begin
                    next_ctrl = wr_data[`SSR_FRAME_W-1:0] & `SSR_CTRL_WMASK;
                end
            end else if (reg_ofs(wr_addr) == `SSR_OFS_BUF) begin
                // buffer is read only: write accepted and ignored
                wr_err = 1'b0;
            end else if (reg_ofs(wr_addr) == `SSR_OFS_STAT) begin
                if (wr_strb[0]) begin
                    stat_clr = wr_data[`SSR_ST_W-1:0];
                end
            end else if (reg_ofs(wr_addr) == `SSR_OFS_MASK) begin
                if (wr_strb[0]) begin
                    next_mask = wr_data[`SSR_ST_W-1:0];
                end
            end else begin
                wr_err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `SSR_CTRL_RST;
            mask <= `SSR_MASK_RST;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link sampling and shifting
    always_comb begin
        next_rxc_prev = rxc_s;
        next_sample = sample;
        // last value seen while low is the bit shifted
        if (!rxc_s) begin
            next_sample = rxd_s;
        end
        next_shift_reg = shift_reg;
        next_bit_cnt = bit_cnt;
        next_state = state;
        // clearing enable drops a partial frame
        if (!rx_en) begin
            next_bit_cnt = '0;
            next_state = ssr_pkg::SSR_IDLE;
        end else if (shift_clk) begin
            next_shift_reg = shifted;
            if (frame_done) begin
                next_bit_cnt = '0;
                next_state = ssr_pkg::SSR_IDLE;
            end else begin
                next_bit_cnt = cnt_inc;
                next_state = ssr_pkg::SSR_RECV;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rxc_prev <= 1'b1;
            sample <= 1'b0;
            shift_reg <= `SSR_BUF_RST;
            bit_cnt <= '0;
            state <= ssr_pkg::SSR_IDLE;
        end else begin
            rxc_prev <= next_rxc_prev;
            sample <= next_sample;
            shift_reg <= next_shift_reg;
            bit_cnt <= next_bit_cnt;
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame results and completion
    always_comb begin
        next_rx_buf = rx_buf;
        // a buffer read in the completing cycle counts as read
        next_unread = unread && !buf_read;
        next_pend_done = pend_done;
        next_pend_ovr = pend_ovr;
        if (frame_done) begin
            next_rx_buf = frame_align(shifted, frame_len);
            next_unread = 1'b1;
            next_pend_done = 1'b1;
            // overrun held until the strobe reports it
            next_pend_ovr = pend_ovr || (unread && !buf_read);
        end

        // completion reported on the next instruction start
        stat_set = '0;
        next_receive_complete = 1'b0;
        if (instruction_start_strobe && pend_done) begin
            next_receive_complete = 1'b1;
            stat_set[`SSR_ST_DONE_BIT] = 1'b1;
            stat_set[`SSR_ST_OVR_BIT] = pend_ovr;
            next_pend_done = frame_done;
            next_pend_ovr = frame_done && unread && !buf_read;
        end
        // a new set wins over a write-one clear
        next_status = (status & ~stat_clr) | stat_set;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status <= `SSR_ST_RST;
            rx_buf <= `SSR_BUF_RST;
            unread <= 1'b0;
            pend_done <= 1'b0;
            pend_ovr <= 1'b0;
            receive_complete <= 1'b0;
        end else begin
            status <= next_status;
            rx_buf <= next_rx_buf;
            unread <= next_unread;
            pend_done <= next_pend_done;
            pend_ovr <= next_pend_ovr;
            receive_complete <= next_receive_complete;
        end
    end
endmodule : ssr_receiver

`default_nettype wire

/* File: testbench/ssr_assertions.sv */
/*
 * checker of the serial slave receiver, bound to its top ports.
 * assumes ssr_map.svh on the include path and one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module ssr_assertions (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SSR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`SSR_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic instruction_start_strobe,
    input wire logic receive_complete,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 28'h0
        |=> s_axi_rresp == `SSR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RC_STROBE: assert property (receive_complete |-> $past(instruction_start_strobe))
        else $error("completion not aligned to strobe");
    AST_RC_PULSE: assert property (receive_complete |=> !receive_complete)
        else $error("completion longer than one cycle");

    cover property (receive_complete);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == `SSR_RESP_SLVERR);
endmodule : ssr_assertions

bind ssr_receiver ssr_assertions u_chk (.clk_sys, .rstn, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instruction_start_strobe,
    .receive_complete, .irq);

`default_nettype wire

/* File: testbench/ssr_tx_model.sv */
/*
 * external serial transmitter: makes the receive clock and data.
 * assumes a slave that samples data while the clock is low.
 */
`timescale 1ns/10ps
`default_nettype none

module ssr_tx_model (
    output logic sclk,
    output logic sdat
);
    // clock stands high between frames
    initial begin
        sclk = 1'b1;
        sdat = 1'b0;
    end

    task automatic send(input logic [7:0] d, input int n, input bit slow);
        #1.3;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            sdat = d[i];
            #80;
            sclk = 1'b1;
            #10;
            // hold over, undriven line shows the inverse
            sdat = ~d[i];
            #(slow ? 230 : 70);
        end
    endtask : send
endmodule : ssr_tx_model

`default_nettype wire

/* File: testbench/sync_serial_slave_receiver_test.sv */
/*
 * self-checking bench of the serial slave receiver with a frame model.
 * assumes the transmitter model and the checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ssr_map.svh"

module sync_serial_slave_receiver_test;
    logic clk_sys = 1'b0, rstn = 1'b0, instruction_start_strobe = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_rdata, rd_v;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic receive_clock_pin, receive_data_pin, receive_complete, irq;
    int error_cnt, total_checks, cyc, exp_buf;
    bit unread, ovr, done, pend;

    ssr_tx_model u_tx (.sclk(receive_clock_pin), .sdat(receive_data_pin));
    ssr_receiver u_dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receive_clock_pin, .receive_data_pin,
        .instruction_start_strobe, .receive_complete, .irq);

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // ready and valid come from registers: read them settled at the falling edge,
    // the transfer then happens at the next rising edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit aw_go;
        bit w_go;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_go = 1'b0;
        w_go = 1'b0;
        while (!aw_go || !w_go) begin
            @(negedge clk_sys);
            aw_go = aw_go || s_axi_awready;
            w_go = w_go || s_axi_wready;
            @(posedge clk_sys);
            if (aw_go) s_axi_awvalid <= 1'b0;
            if (w_go) s_axi_wvalid <= 1'b0;
        end
        do @(negedge clk_sys); while (!s_axi_bvalid);
        chk("write resp", 32'(s_axi_bresp), 32'(`SSR_RESP_OKAY));
        @(posedge clk_sys);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk_sys); while (!s_axi_arready);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_sys); while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        rd_r = s_axi_rresp;
        @(posedge clk_sys);
        s_axi_rready <= 1'b0;
        if (a == `SSR_OFS_BUF) unread = 1'b0;
    endtask : rd

    // frame sent by the far side and its expected effect
    task automatic frame(input int len, input bit en, input bit slow);
        logic [7:0] d;
        d = 8'($urandom);
        u_tx.send(d, len, slow);
        if (en) begin
            if (unread) ovr = 1'b1;
            exp_buf = int'(d) & ((1 << len) - 1);
            unread = 1'b1;
            done = 1'b1;
            pend = 1'b1;
        end
    endtask : frame

    task automatic strobe();
        @(posedge clk_sys);
        instruction_start_strobe <= 1'b1;
        @(posedge clk_sys);
        instruction_start_strobe <= 1'b0;
        #1;
        chk("complete", 32'(receive_complete), 32'(pend));
        pend = 1'b0;
    endtask : strobe

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'he7a10826));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(32'(i * 4));
            chk("reset value", rd_v, i == 0 ? 32'(`SSR_CTRL_RST) : 32'h0);
        end
        rd(32'h10);
        chk("unmapped resp", 32'(rd_r), 32'(`SSR_RESP_SLVERR));
        $display("test reset done");

        frame(8, 1'b0, 1'b0);
        strobe();
        rd(`SSR_OFS_STAT);
        chk("status idle", rd_v, 32'h0);
        $display("test disabled done");

        wr(`SSR_OFS_MASK, 32'h1);
        for (int l = 1; l <= 8; l++) begin
            wr(`SSR_OFS_CTRL, 32'h80 | 32'(l - 1));
            frame(l, 1'b1, l == 3);
            strobe();
            chk("irq set", 32'(irq), 32'h1);
            rd(`SSR_OFS_BUF);
            chk("buffer", rd_v, 32'(exp_buf));
            rd(`SSR_OFS_STAT);
            chk("status", rd_v, {30'h0, ovr, done});
            wr(`SSR_OFS_STAT, 32'h3);
            done = 1'b0;
            ovr = 1'b0;
            chk("irq clear", 32'(irq), 32'h0);
            rd(`SSR_OFS_CTRL);
            chk("ctrl", rd_v, 32'h80 | 32'(l - 1));
        end
        $display("test lengths done");

        frame(8, 1'b1, 1'b0);
        frame(8, 1'b1, 1'b0);
        strobe();
        rd(`SSR_OFS_BUF);
        chk("second frame", rd_v, 32'(exp_buf));
        rd(`SSR_OFS_STAT);
        chk("overrun", rd_v, {30'h0, ovr, done});
        $display("test overrun done");
        stop_test();
    end
endmodule : sync_serial_slave_receiver_test

`default_nettype wire
